/* sensor_spi_slave_frames.sv */
// Serial slave frame engine: receives requests, returns answers
// one frame later. Assumes a mode-zero master on the pins and a
// register file on the core side that answers in the same cycle.
//
// What this block does
// - Slave only, separate input and output data lines, no three-wire mode.
// - Each frame carries a new request and the answer to the previous one.
// - Act only on frames of exactly 32 or 48 bits with valid checksum.
// - Frame starts on chip-select fall and ends on its rise.
// - Clock idles low, inputs sampled rising, outputs changed falling.
// - Top two address bits select the slave; low eight address the register.
// - Access bit is 0 for read, 1 for write.
// - Frame-type bit picks next answer width: 0 short, 1 long.
// - Answer echoes the full ten-bit address of the answered request.
// - Data-kind flag is 1 only for reads of sensor data registers.
// - Request payload is 20 bits in long, 16 bits in short frames.
// - Short answers carry the top 16 of the 20 payload bits.
// - The seven reserved request bits of long frames are ignored.
// - Unused answer positions are ignored on receive and sent as zero.
// - Command error flags bad content; protocol faults float the output.
// - Long answers set the internal status flag on common-cause error.
// - Wrapping four-bit sample counter sent in long sensor answers.
// - Long checksum covers bits 47 to 8, sits in bits 7 to 0.
// - Short checksum covers bits 31 to 3, sits in bits 2 to 0.
// - Accept a frame only when its select bits match the strap inputs.
// - Status 00 normal, 01 error, 10 saturation.
// - Long checksum poly 100101111, start all ones, MSB first, no inversion.
// - Short checksum poly 1011, start 101, MSB first, no inversion.
// - Status 11 is initialisation; priority init, error, saturation, normal.
// - Answers to writes always carry status 00.
`timescale 1ns/1ns

module sensor_spi_slave_frames
  import spi_frame_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Serial pins
  input  wire logic        spi_clk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Address straps
  input  wire logic        slave_strap_high_i,
  input  wire logic        slave_strap_low_i,
  // Request towards the register file
  output logic             req_valid_o,
  output logic             req_write_o,
  output logic [7:0]       target_address_o,
  output logic [19:0]      request_payload_o,
  output logic             req_long_o,
  // Same-cycle answer from the register file
  input  wire logic [19:0] resp_data_i,
  input  wire logic        resp_sensor_i,
  input  wire logic        resp_cmd_err_i,
  // Sensor condition
  input  wire logic        init_busy_i,
  input  wire logic        sensor_error_i,
  input  wire logic        sensor_sat_i,
  input  wire logic        common_error_i,
  input  wire logic        new_sample_i,
  output logic [3:0]       sample_count_o
);

  // ==========================================================
  // Checksum helpers

  // Long checksum over a 40-bit field, MSB first
  function automatic logic [7:0] long_frame_checksum_calc(input logic [39:0] d);
    logic [7:0] c;
    c = LONG_FRAME_CHECKSUM_INIT;
    for (int i = 39; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ LONG_FRAME_CHECKSUM_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Short checksum over a 29-bit field, MSB first
  function automatic logic [2:0] short_frame_checksum_calc(input logic [28:0] d);
    logic [2:0] c;
    c = SHORT_FRAME_CHECKSUM_INIT;
    for (int i = 28; i >= 0; i--) begin
      if (c[2] ^ d[i]) begin
        c = {c[1:0], 1'b0} ^ SHORT_FRAME_CHECKSUM_POLY;
      end else begin
        c = {c[1:0], 1'b0};
      end
    end
    return c;
  endfunction

  // ==========================================================
  // Link domain: frame marker clocked by chip select

  logic       frame_id_r;
  logic       rx_id_r;
  logic       tx_id_r;
  logic [47:0] rx_shift_r;
  logic [5:0] rx_cnt_r;
  logic [5:0] tx_cnt_r;
  logic [47:0] tx_word_r;
  logic       tx_ok_r;

  // Flips at each frame start; lets both edges see a new frame
  always_ff @(negedge cs_n_i or posedge rst_i) begin
    if (rst_i) begin
      frame_id_r <= 1'b0;
    end else begin
      frame_id_r <= ~frame_id_r;
    end
  end

  // Input shift on rising edges, restarted on a new frame
  always_ff @(posedge spi_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_id_r    <= 1'b0;
      rx_shift_r <= '0;
      rx_cnt_r   <= '0;
    end else if (rx_id_r != frame_id_r) begin
      rx_id_r    <= frame_id_r;
      rx_shift_r <= {47'h0, mosi_i};
      rx_cnt_r   <= 6'h01;
    end else begin
      rx_shift_r <= {rx_shift_r[46:0], mosi_i};
      // Saturate so overlong frames never alias to a legal length
      if (rx_cnt_r != LEN_MAX) begin
        rx_cnt_r <= rx_cnt_r + 6'h01;
      end
    end
  end

  // Output bit index advanced on falling edges
  always_ff @(negedge spi_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_id_r  <= 1'b0;
      tx_cnt_r <= '0;
    end else if (tx_id_r != frame_id_r) begin
      tx_id_r  <= frame_id_r;
      tx_cnt_r <= 6'h01;
    end else if (tx_cnt_r != LEN_MAX) begin
      tx_cnt_r <= tx_cnt_r + 6'h01;
    end
  end

  // Answer word is static while the frame runs; bits past it are 0
  logic [5:0] tx_pos;
  assign tx_pos = (tx_id_r == frame_id_r) ? tx_cnt_r : 6'h00;
  assign miso_o = (tx_pos <= TX_TOP) ? tx_word_r[TX_TOP - tx_pos]
                                     : 1'b0;
  // Driven only inside a frame whose answer is good
  assign miso_oe_o = ~cs_n_i & tx_ok_r;

  // ==========================================================
  // Core domain: synchronisers
  //
  // Crossing plan between the serial clock and the core clock:
  // - chip select and the straps are pins and pass two flops;
  // - the received word, its bit count and the frame marker are
  //   read by the core only after the synchronised chip-select
  //   rise, when no serial edge can move them any more;
  // - the answer word and its enable are written by the core only
  //   after that rise and before the next fall, so the link side
  //   always sees a settled word.
  // Limitation: the host must leave chip select high for several
  // core cycles between frames, or the capture reads a moving word.

  logic       cs_meta_r;
  logic       cs_sync_r;
  logic       cs_prev_r;
  logic [1:0] strap_meta_r;
  logic [1:0] strap_sync_r;

  // Chip select and straps are pins: two flops before use
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_meta_r    <= 1'b1;
      cs_sync_r    <= 1'b1;
      cs_prev_r    <= 1'b1;
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
    end else begin
      cs_meta_r    <= cs_n_i;
      cs_sync_r    <= cs_meta_r;
      cs_prev_r    <= cs_sync_r;
      strap_meta_r <= {slave_strap_high_i, slave_strap_low_i};
      strap_sync_r <= strap_meta_r;
    end
  end

  logic frame_end;
  assign frame_end = cs_sync_r & ~cs_prev_r;

  // ==========================================================
  // Core domain: sample counter

  logic [3:0] sample_cnt_r;

  // Wraps naturally at four bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_cnt_r <= '0;
    end else if (new_sample_i) begin
      sample_cnt_r <= sample_cnt_r + 4'h1;
    end
  end
  assign sample_count_o = sample_cnt_r;

  // ==========================================================
  // Core domain: capture and check of the finished request

  step_t      step_r;
  logic [47:0] cap_word_r;
  logic [5:0] cap_len_r;
  logic       cap_fresh_r;

  // Link flops are quiet once chip select is high, so the
  // synchronised rise acts as the handshake for the capture.
  // Capture and evaluation take one cycle each; splitting them
  // keeps the checksum trees off the path from the link flops.
  // A frame without serial clocks leaves the marker unmatched,
  // which marks the capture stale and the request refused.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_r      <= ST_IDLE;
      cap_word_r  <= '0;
      cap_len_r   <= '0;
      cap_fresh_r <= 1'b0;
    end else begin
      case (step_r)
        ST_IDLE: begin
          if (frame_end) begin
            step_r <= ST_CAPT;
          end
        end
        ST_CAPT: begin
          cap_word_r  <= rx_shift_r;
          cap_len_r   <= rx_cnt_r;
          // No clock edges in this frame means nothing received
          cap_fresh_r <= (rx_id_r == frame_id_r);
          step_r      <= ST_EVAL;
        end
        ST_EVAL: begin
          step_r <= ST_IDLE;
        end
        default: begin
          step_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Field decode of the captured request
  logic        is_long;
  logic        is_short;
  logic [9:0]  ta_full;
  logic        rw_bit;
  logic        ft_bit;
  logic [19:0] pay;
  logic        crc_ok;
  logic        sel_ok;
  logic        accept;

  assign is_long  = cap_fresh_r && (cap_len_r == LEN_LONG);
  assign is_short = cap_fresh_r && (cap_len_r == LEN_SHORT);

  // Reserved bits of long requests are read only by the checksum
  always_comb begin
    if (is_long) begin
      ta_full = cap_word_r[L_TA_HI:L_TA_LO];
      rw_bit  = cap_word_r[L_RW];
      ft_bit  = cap_word_r[L_FT];
      pay     = cap_word_r[L_DAT_HI:L_DAT_LO];
      crc_ok  = long_frame_checksum_calc(cap_word_r[47:8]) == cap_word_r[7:0];
    end else begin
      ta_full = cap_word_r[S_TA_HI:S_TA_LO];
      rw_bit  = cap_word_r[S_RW];
      ft_bit  = cap_word_r[S_FT];
      pay     = {4'h0, cap_word_r[S_DAT_HI:S_DAT_LO]};
      crc_ok  = short_frame_checksum_calc(cap_word_r[31:3]) == cap_word_r[2:0];
    end
  end

  assign sel_ok = (ta_full[9:8] == strap_sync_r);
  assign accept = (step_r == ST_EVAL) && (is_long || is_short)
                  && crc_ok && sel_ok;

  // ==========================================================
  // Request strobe to the register file

  assign req_valid_o       = accept;
  assign req_write_o       = rw_bit;
  assign target_address_o  = ta_full[7:0];
  assign request_payload_o = pay;
  assign req_long_o        = is_long;

  // ==========================================================
  // Answer assembly
  //
  // The register file answers in the cycle of the strobe, so the
  // whole answer word is built combinationally and latched once.
  // Both widths are built every time; the frame-type bit of the
  // request being answered picks which one is latched.
  // Trade-off: two checksum trees cost area, but no extra cycle.

  logic [1:0]  status;
  logic        kind;
  logic [47:0] long_word;
  logic [31:0] short_word;

  // Status by priority; writes always report normal
  always_comb begin
    if (rw_bit) begin
      status = ST_NORMAL;
    end else if (init_busy_i) begin
      status = ST_INIT;
    end else if (sensor_error_i) begin
      status = ST_ERROR;
    end else if (sensor_sat_i) begin
      status = ST_SAT;
    end else begin
      status = ST_NORMAL;
    end
  end

  assign kind = resp_sensor_i & ~rw_bit;

  // Long answer; counter field is zero for non-sensor data
  always_comb begin
    long_word[47]    = kind;
    long_word[46:37] = ta_full;
    long_word[36]    = common_error_i;
    long_word[35]    = resp_cmd_err_i;
    long_word[34:33] = status;
    long_word[32:29] = kind ? sample_cnt_r : 4'h0;
    long_word[28]    = 1'b0;
    long_word[27:8]  = resp_data_i;
    long_word[7:0]   = long_frame_checksum_calc(long_word[47:8]);
  end

  // Short answer keeps the top sixteen payload bits
  always_comb begin
    short_word[31]    = kind;
    short_word[30:21] = ta_full;
    short_word[20]    = status[1];
    short_word[19:4]  = resp_data_i[19:4];
    short_word[3]     = status[0];
    short_word[2:0]   = short_frame_checksum_calc(short_word[31:3]);
  end

  // Held until the next evaluated frame; a rejected request
  // floats the output for the whole next frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_word_r <= '0;
      tx_ok_r   <= 1'b0;
    end else if (step_r == ST_EVAL) begin
      tx_ok_r <= accept;
      if (accept) begin
        tx_word_r <= ft_bit ? long_word
                            : {short_word, 16'h0000};
      end
    end
  end

endmodule

/* sensor_spi_slave_frames_assertions.sv */
// Port checker for the serial frame engine.
// Bound to the engine from the bench; sees its ports only.
`timescale 1ns/1ns
module sensor_spi_slave_frames_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        spi_clk_i,
  input wire logic        cs_n_i,
  input wire logic        miso_o,
  input wire logic        miso_oe_o,
  input wire logic        req_valid_o,
  input wire logic        req_long_o,
  input wire logic [19:0] request_payload_o,
  input wire logic        new_sample_i,
  input wire logic [3:0]  sample_count_o
);
  // ==========================================================
  // Pin and strobe relations, all in the core domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_oe_idle: assert property (cs_n_i |-> !miso_oe_o)
    else $error("answer driven outside a frame");
  chk_oe_steady: assert property (!cs_n_i && !$past(cs_n_i) |-> $stable(miso_oe_o))
    else $error("answer enable changed inside a frame");
  // Serial clock half period spans two core samples
  chk_miso_hold: assert property (miso_oe_o && spi_clk_i && $past(spi_clk_i)
    |-> $stable(miso_o))
    else $error("answer bit changed while serial clock high");
  chk_req_single: assert property (req_valid_o |=> !req_valid_o)
    else $error("request strobe longer than one cycle");
  chk_req_after_end: assert property (req_valid_o |-> cs_n_i)
    else $error("request issued before frame end");
  chk_short_pay: assert property (req_valid_o && !req_long_o
    |-> request_payload_o[19:16] == 4'h0)
    else $error("short payload wider than 16 bits");
  chk_cnt_step: assert property (new_sample_i
    |=> sample_count_o == $past(sample_count_o) + 4'h1)
    else $error("sample counter did not step");
  chk_cnt_hold: assert property (!new_sample_i |=> $stable(sample_count_o))
    else $error("sample counter moved without a sample");
endmodule

/* spi_frame_pkg.sv */
// Constants for the sensor serial slave frame logic.
// Assumes a mode-zero master and a 100 MHz core clock.
package spi_frame_pkg;

  // ==========================================================
  // Frame lengths and counters
  localparam int          LONG_BITS  = 48;
  localparam int          SHORT_BITS = 32;
  localparam logic [5:0]  LEN_LONG   = 6'h30;
  localparam logic [5:0]  LEN_SHORT  = 6'h20;
  localparam logic [5:0]  LEN_MAX    = 6'h3F;
  localparam logic [5:0]  TX_TOP     = 6'h2F;

  // ==========================================================
  // Long request layout (bit 47 down)
  localparam int L_TA_HI  = 47;
  localparam int L_TA_LO  = 38;
  localparam int L_RW     = 37;
  localparam int L_FT     = 35;
  localparam int L_DAT_HI = 27;
  localparam int L_DAT_LO = 8;

  // Short request layout (bit 31 down)
  localparam int S_TA_HI  = 31;
  localparam int S_TA_LO  = 22;
  localparam int S_RW     = 21;
  localparam int S_FT     = 19;
  localparam int S_DAT_HI = 18;
  localparam int S_DAT_LO = 3;

  // ==========================================================
  // Checksums
  localparam logic [7:0] LONG_FRAME_CHECKSUM_POLY = 8'h2F;
  localparam logic [7:0] LONG_FRAME_CHECKSUM_INIT = 8'hFF;
  localparam logic [2:0] SHORT_FRAME_CHECKSUM_POLY = 3'h3;
  localparam logic [2:0] SHORT_FRAME_CHECKSUM_INIT = 3'h5;

  // ==========================================================
  // Sensor status codes
  localparam logic [1:0] ST_NORMAL = 2'h0;
  localparam logic [1:0] ST_ERROR  = 2'h1;
  localparam logic [1:0] ST_SAT    = 2'h2;
  localparam logic [1:0] ST_INIT   = 2'h3;

  // Request handling steps in the core domain
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAPT,
    ST_EVAL
  } step_t;

endpackage

/* spi_host_model.sv */
// Host master model driving the serial pins in clock mode zero.
// Assumes one caller at a time; serial clock period 48 ns.
`timescale 1ns/1ns
module spi_host_model (
  output logic      spi_clk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  // ==========================================================
  // Idle pins: clock low and stopped between frames
  initial begin
    spi_clk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One frame of n bits, MSB first, left aligned in tx and rx
  task automatic xfer(input logic [47:0] tx, input int n,
                      output logic [47:0] rx, output logic [47:0] oe);
    rx = '0;
    oe = '0;
    mosi_o = tx[47];
    cs_n_o = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      spi_clk_o = 1'b1;
      rx[47-i] = miso_i;
      oe[47-i] = miso_oe_i;
      #24;
      spi_clk_o = 1'b0;
      if (i < n - 1) mosi_o = tx[46-i];
      #24;
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line must not hold the last bit
    #200; // Covers the sync and evaluation gap
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the serial frame engine.
// Host model drives the pins; a small register file answers here.
`timescale 1ns/1ns
module tb_top;
  import spi_frame_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, sh = 1'b0, sl = 1'b1;
  logic        ini = 1'b0, err = 1'b0, sat = 1'b0, com = 1'b0, nsm = 1'b0;
  logic        spi_clk, cs_n, mosi, miso, miso_oe, rv, rw_o, lg_o, rsen, rce;
  logic        c_w, c_l, e_oe = 1'b0, e_lg = 1'b0;
  logic [7:0]  ta_o, c_a;
  logic [19:0] pay_o, rdat, c_p;
  logic [3:0]  cnt, cexp;
  logic [47:0] e_fr, e_m;
  int          fails = 0, checks = 0, nreq = 0, nexp = 0;
  // ==========================================================
  // Clock, register file and request capture
  always #5 clk_i = ~clk_i;
  function automatic logic [19:0] rf(input logic [7:0] a);
    return {a, 12'hC35};
  endfunction
  function automatic logic sens(input logic [7:0] a);
    return a inside {[8'h01:8'h10]};
  endfunction
  assign rdat = rf(ta_o);
  assign rsen = sens(ta_o);
  assign rce  = ta_o == 8'hFF;
  // Strobe is combinational from registers: sample mid-cycle, away from the launching edge
  always @(negedge clk_i) begin
    if (rv === 1'b1) begin
      nreq++;
      {c_w, c_a, c_p, c_l} = {rw_o, ta_o, pay_o, lg_o};
    end
  end
  sensor_spi_slave_frames i_dut (.clk_i(clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .slave_strap_high_i(sh), .slave_strap_low_i(sl), .req_valid_o(rv),
    .req_write_o(rw_o), .target_address_o(ta_o), .request_payload_o(pay_o),
    .req_long_o(lg_o), .resp_data_i(rdat), .resp_sensor_i(rsen), .resp_cmd_err_i(rce),
    .init_busy_i(ini), .sensor_error_i(err), .sensor_sat_i(sat),
    .common_error_i(com), .new_sample_i(nsm), .sample_count_o(cnt));
  spi_host_model u_host (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));
  // ==========================================================
  // Shared helpers
  function automatic logic [7:0] crc(input logic [47:0] f, input int n);
    logic [7:0] c, p;
    int         w;
    logic       b;
    w = n == 48 ? 8 : 3;
    c = n == 48 ? LONG_FRAME_CHECKSUM_INIT : {5'h0, SHORT_FRAME_CHECKSUM_INIT};
    p = n == 48 ? LONG_FRAME_CHECKSUM_POLY : {5'h0, SHORT_FRAME_CHECKSUM_POLY};
    for (int i = n - 1; i >= w; i--) begin
      b = f[i] ^ c[w-1];
      c = {c[6:0], 1'b0} ^ (b ? p : 8'h0);
    end
    return n == 48 ? c : {5'h0, c[2:0]};
  endfunction
  task automatic chk(input string nm, input logic [47:0] e, g, m);
    checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One frame: judge the answer to the last request, then set up the next one.
  // bad 1 spoils the checksum, bad 2 cuts the frame to 40 bits.
  task automatic go(input logic [9:0] a, input logic w, ft, lg, input logic [19:0] d,
                    input int bad);
    logic [47:0] tx, rx, oe, cm;
    logic [19:0] v;
    logic [1:0]  st;
    logic        k, kd;
    int          n;
    @(posedge clk_i);
    #1;
    n = bad == 2 ? 40 : (lg ? 48 : 32);
    tx = lg ? {a, w, 1'b0, ft, 7'h2A, d, 8'h0} : {a, w, 1'b0, ft, d[15:0], 19'h0};
    if (lg) tx[7:0] = crc(tx, 48) ^ {7'h0, bad == 1};
    else tx[18:16] = crc(tx >> 16, 32) ^ {2'h0, bad == 1};
    u_host.xfer(tx, n, rx, oe);
    cm = ~48'h0 << (48 - n);
    chk("miso_oe", {48{e_oe}}, oe, cm);
    if (e_oe) begin
      chk("answer", e_fr, rx, e_m);
      chk("checksum", {40'h0, crc(e_lg ? rx : rx >> 16, e_lg ? 48 : 32)},
          {40'h0, e_lg ? rx[7:0] : {5'h0, rx[18:16]}}, 48'hFF);
    end
    k = bad == 0 && a[9:8] == {sh, sl};
    nexp += k;
    chk("req_count", 48'(nexp), 48'(nreq), '1);
    if (k) chk("request", {18'h0, w, a[7:0], lg ? d : {4'h0, d[15:0]}, lg},
               {18'h0, c_w, c_a, c_p, c_l}, '1);
    st = w ? ST_NORMAL : ini ? ST_INIT : err ? ST_ERROR : sat ? ST_SAT : ST_NORMAL;
    kd = !w && sens(a[7:0]);
    v = rf(a[7:0]);
    e_oe = k;
    e_lg = ft;
    if (ft) e_fr = {kd, a, com, a[7:0] == 8'hFF, st, kd ? cexp : 4'h0, 1'b0, v, 8'h0};
    else e_fr = {kd, a, st[1], v[19:4], st[0], 19'h0};
    e_m = ft ? (w ? 48'hFFEFF0000000 : 48'hFFFFFFFFFF00)
             : (w ? 48'hFFF000080000 : 48'hFFFFFFF80000);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_count;
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_i);
      #1 nsm = 1'b1;
      @(posedge clk_i);
      #1 nsm = 1'b0;
    end
    cexp = 4'h1;
    chk("sample_count", {44'h0, cexp}, {44'h0, cnt}, 48'hF);
  endtask
  task automatic t_status;
    logic [2:0] cfg [4];
    cfg = '{3'b111, 3'b011, 3'b001, 3'b000};
    for (int i = 0; i < 4; i++) begin
      {ini, err, sat} = cfg[i];
      com = cfg[i][2];
      go({2'b01, 8'h01 + 8'(i)}, 1'b0, 1'b1, 1'b1, 20'h0, 0);
    end
  endtask
  task automatic t_mixed;
    err = 1'b1;
    go(10'h135, 1'b1, 1'b0, 1'b1, 20'h12345, 0);
    go(10'h114, 1'b0, 1'b0, 1'b0, 20'h0, 0);
    go(10'h1FF, 1'b0, 1'b1, 1'b0, 20'h0, 0);
    go(10'h110, 1'b0, 1'b1, 1'b1, 20'h0, 0);
  endtask
  task automatic t_refuse;
    for (int b = 0; b < 3; b++) begin
      go(b == 2 ? 10'h201 : 10'h101, 1'b0, 1'b1, 1'b1, 20'h0, b < 2 ? b + 1 : 0);
      go(10'h102, 1'b0, 1'b0, 1'b0, 20'h0, 0);
    end
    go(10'h103, 1'b0, 1'b1, 1'b1, 20'h0, 0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    t_count;
    t_status;
    t_mixed;
    t_refuse;
    wrap_up;
  end
  initial begin
    #300000;
    fails++;
    wrap_up;
  end
endmodule
bind sensor_spi_slave_frames sensor_spi_slave_frames_assertions u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .spi_clk_i(spi_clk_i), .cs_n_i(cs_n_i), .miso_o(miso_o),
  .miso_oe_o(miso_oe_o), .req_valid_o(req_valid_o), .req_long_o(req_long_o),
  .request_payload_o(request_payload_o), .new_sample_i(new_sample_i),
  .sample_count_o(sample_count_o));
